// ### rtl/ltw_pkg.sv
// Constants, register map and types for the list trigger/wait sequencer.
// Assumes a 50 MHz aclk; all programmed times are held in microseconds.
package ltw_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned US_PER_S = 1_000_000;
    localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;
    // Legal time window 0.00025 s to 0.034 s, held in microseconds.
    localparam logic [15:0] T_MIN_US = 16'h00fa;
    localparam logic [15:0] T_MAX_US = 16'h84d0;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WAIT = 8'h04;
    localparam logic [7:0] OFS_TRIG = 8'h08;
    localparam logic [7:0] OFS_SAMP = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_POINT = 8'h14;
    localparam logic [7:0] OFS_DWELL = 8'h18;
    localparam logic [7:0] OFS_LOOP = 8'h1c;
    localparam logic [7:0] OFS_SPT = 8'h20;
    localparam logic [7:0] OFS_SAVE = 8'h24;
    localparam logic [7:0] OFS_NAME = 8'h28;
    // Field positions.
    localparam int unsigned CTRL_RUN = 0;
    localparam int unsigned CTRL_CLR = 1;
    localparam int unsigned CTRL_TYPE_LO = 2;
    localparam int unsigned TRIG_POL = 16;
    localparam int unsigned PT_KIND_LO = 16;
    localparam int unsigned PT_INIT = 18;
    localparam int unsigned NAME_QUOTE = 8;
    localparam int unsigned SPT_CURR = 16;
    // Error magnitudes (reported as negative numbers by software).
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_CMD = 8'h64;
    localparam logic [7:0] ERR_CONFLICT = 8'hdd;
    localparam logic [7:0] ERR_RANGE = 8'hde;
    localparam logic [7:0] ERR_LEN = 8'he2;
    // Waveform save limits and name characters.
    localparam logic [4:0] SAVE_SLOTS = 5'h10;
    localparam int unsigned SAVE_SEGS = 10;
    localparam int unsigned NAME_MAX = 10;
    localparam logic [7:0] CH_LO_A = 8'h61;
    localparam logic [7:0] CH_LO_Z = 8'h7a;
    localparam logic [7:0] CH_CASE = 8'h20;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        LTW_TY_NONE, LTW_TY_VOLT, LTW_TY_CURR, LTW_TY_RSVD
    } ltw_type_e;
    typedef enum logic [1:0] {
        LTW_PK_LEVEL, LTW_PK_PULSE, LTW_PK_WAITHI, LTW_PK_WAITLO
    } ltw_kind_e;
    typedef enum logic [2:0] {
        LTW_IDLE, LTW_LOAD, LTW_LEVEL, LTW_PULSE, LTW_WAITHI, LTW_WAITLO
    } ltw_state_e;
endpackage : ltw_pkg

// ### rtl/ltw_sequencer.sv
// List sequencer with output trigger pulses and trigger-input waits.
// Assumes an AXI4-Lite master on aclk; trig_in is an asynchronous pin.
//
// What this block does
// - Wait-high point holds level, advances on trigger high or time-out.
// - Wait time-out accepts 0.00025 to 0.034 s and reads back stored.
// - Unprogrammed time-out stays zero, meaning wait forever for trigger.
// - Pulse width accepts 0.00025 to 0.034 s; early read is error.
// - Polarity picks switch conducting or open during an active pulse.
// - Pulse configuration makes switch an output trigger until list clear.
// - Pulse point drives level and holds switch state for pulse width.
// - Pulse point without configured width is a settings conflict.
// - Pulse point before list type is set is a settings conflict.
// - Dwell and level lists of unequal length raise length mismatch.
// - First-pass segments run once; last point always repeats.
// - Sample width accepts 0.00025 to 0.034 s, settable once until list clear.
// - Sample report gives point index and voltage or current mark.
// - Sample width read before setting is a command error.
// - Save stores up to ten segments in slot 1..16 with loop count.
// - Unquoted lower-case name letters become upper case.
// - Wait-low point holds level until trigger input is low.
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
module ltw_sequencer #(
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW = 4
) (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic awvalid, // Write address valid.
    output logic awready, // Write address ready.
    input wire logic [7:0] awaddr, // Write byte address.
    input wire logic wvalid, // Write data valid.
    output logic wready, // Write data ready.
    input wire logic [31:0] wdata, // Write data.
    input wire logic [3:0] wstrb, // Byte strobes, full words assumed.
    output logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    output logic [1:0] bresp, // Write response code.
    input wire logic arvalid, // Read address valid.
    output logic arready, // Read address ready.
    input wire logic [7:0] araddr, // Read byte address.
    output logic rvalid, // Read data valid.
    input wire logic rready, // Read data ready.
    output logic [31:0] rdata, // Read data.
    output logic [1:0] rresp, // Read response code.
    input wire logic trig_in, // Trigger input pin from the instrument.
    input wire logic out_off_flag, // Output-off indication, normal role.
    output logic iso_switch_conduct, // High: isolated switch conducts.
    output logic [15:0] level_out, // Programmed level of current point.
    output logic list_running // High while the list executes.
);
    import ltw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic aw_ok_r, w_ok_r, bvalid_r, rvalid_r, wr_go;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r, rd_val;
    logic [1:0] bresp_r, rresp_r;
    logic [7:0] wr_err, rd_err, err_code_r;
    logic [15:0] wait_to_r, trig_w_r, samp_w_r, elapsed_r, loop_r, pass_r;
    logic trig_set_r, samp_set_r, pol_r, trig_role_r, rd_bad;
    logic [1:0] type_r;
    logic [AW:0] n_lvl_r, n_dw_r, samp_pt_r;
    logic [AW-1:0] idx_r;
    logic [18:0] pt_mem [DEPTH];
    logic [15:0] dw_mem [DEPTH];
    logic [7:0] name_mem [NAME_MAX];
    logic [3:0] name_len_r, save_segs_r;
    logic [4:0] save_slot_r;
    logic [15:0] save_loop_r;
    logic s1_r, s2_r, s3_r, trig_lvl_r;
    logic [5:0] pre_r;
    logic tick;
    ltw_state_e st_r;
    logic [15:0] wv;
    logic [18:0] cur_pt;
    logic last_pt;

    assign wv = w_data_r[15:0];
    assign awready = !aw_ok_r && !bvalid_r;
    assign wready = !w_ok_r && !bvalid_r;
    assign wr_go = aw_ok_r && w_ok_r && !bvalid_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = !rvalid_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign list_running = (st_r != LTW_IDLE);
    assign cur_pt = pt_mem[idx_r];
    assign last_pt = ({1'b0, idx_r} == n_lvl_r - 1'b1);

    function automatic logic in_win(input logic [15:0] v);
        return (v >= T_MIN_US) && (v <= T_MAX_US);
    endfunction : in_win

    ////////////////////////////////////////////////////////////////////////
    // Bus write channels are taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_ok_r <= 1'b1;
                aw_addr_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_ok_r <= 1'b1;
                w_data_r <= wdata;
            end
            if (wr_go) begin
                aw_ok_r <= 1'b0;
                w_ok_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (wr_err == ERR_NONE) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Write checks; a nonzero code rejects the write.
    always_comb begin
        wr_err = ERR_NONE;
        unique case (aw_addr_r)
            OFS_CTRL: begin
                if (w_data_r[CTRL_RUN] && st_r == LTW_IDLE &&
                    n_lvl_r != n_dw_r) begin
                    wr_err = ERR_LEN;
                end
            end
            OFS_WAIT: wr_err = in_win(wv) ? ERR_NONE : ERR_RANGE;
            OFS_TRIG: wr_err = in_win(wv) ? ERR_NONE : ERR_RANGE;
            OFS_SAMP: begin
                if (samp_set_r) wr_err = ERR_CMD;
                else if (!in_win(wv)) wr_err = ERR_RANGE;
            end
            OFS_POINT: begin
                if (w_data_r[PT_KIND_LO +: 2] == LTW_PK_PULSE &&
                    (!trig_set_r || type_r == LTW_TY_NONE))
                    wr_err = ERR_CONFLICT;
                else if (n_lvl_r == DEPTH[AW:0]) wr_err = ERR_RANGE;
            end
            OFS_DWELL: begin
                if (n_dw_r == DEPTH[AW:0]) wr_err = ERR_RANGE;
            end
            OFS_SAVE: begin
                if (w_data_r[4:0] == 5'h00 || w_data_r[4:0] > SAVE_SLOTS ||
                    name_len_r == 4'h0)
                    wr_err = ERR_CMD;
            end
            OFS_NAME: begin
                if (name_len_r == NAME_MAX[3:0]) wr_err = ERR_CMD;
            end
            OFS_LOOP, OFS_STAT, OFS_SPT: wr_err = ERR_NONE;
            default: wr_err = ERR_CMD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers and list clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_to_r <= 16'h0000;
            trig_w_r <= 16'h0000;
            samp_w_r <= 16'h0000;
            trig_set_r <= 1'b0;
            samp_set_r <= 1'b0;
            pol_r <= 1'b0;
            trig_role_r <= 1'b0;
            type_r <= LTW_TY_NONE;
            loop_r <= 16'h0001;
            samp_pt_r <= '0;
            n_lvl_r <= '0;
            n_dw_r <= '0;
            name_len_r <= 4'h0;
            save_slot_r <= 5'h00;
            save_segs_r <= 4'h0;
            save_loop_r <= 16'h0000;
        end else if (wr_go && wr_err == ERR_NONE) begin
            unique case (aw_addr_r)
                OFS_CTRL: begin
                    if (w_data_r[CTRL_CLR]) begin
                        trig_role_r <= 1'b0;
                        trig_set_r <= 1'b0;
                        samp_set_r <= 1'b0;
                        type_r <= LTW_TY_NONE;
                        n_lvl_r <= '0;
                        n_dw_r <= '0;
                        name_len_r <= 4'h0;
                    end else if (w_data_r[CTRL_TYPE_LO +: 2] != LTW_TY_NONE)
                        type_r <= w_data_r[CTRL_TYPE_LO +: 2];
                end
                OFS_WAIT: wait_to_r <= wv;
                OFS_TRIG: begin
                    trig_w_r <= wv;
                    pol_r <= w_data_r[TRIG_POL];
                    trig_set_r <= 1'b1;
                    trig_role_r <= 1'b1;
                end
                OFS_SAMP: begin
                    samp_w_r <= wv;
                    samp_set_r <= 1'b1;
                end
                OFS_POINT: n_lvl_r <= n_lvl_r + 1'b1;
                OFS_DWELL: n_dw_r <= n_dw_r + 1'b1;
                OFS_LOOP: loop_r <= wv;
                OFS_SPT: samp_pt_r <= w_data_r[AW:0];
                OFS_SAVE: begin
                    // keeps segments, slot and loop count
                    save_slot_r <= w_data_r[4:0];
                    save_loop_r <= loop_r;
                    save_segs_r <= (n_lvl_r > SAVE_SEGS[AW:0]) ?
                        SAVE_SEGS[3:0] : 4'(n_lvl_r);
                end
                OFS_NAME: name_len_r <= name_len_r + 1'b1;
                default: ;
            endcase
        end
    end

    // List and name memories.
    always_ff @(posedge aclk) begin
        if (wr_go && wr_err == ERR_NONE) begin
            if (aw_addr_r == OFS_POINT)
                pt_mem[n_lvl_r[AW-1:0]] <= w_data_r[18:0];
            if (aw_addr_r == OFS_DWELL)
                dw_mem[n_dw_r[AW-1:0]] <= wv;
            if (aw_addr_r == OFS_NAME)
                name_mem[name_len_r] <= (!w_data_r[NAME_QUOTE] &&
                    w_data_r[7:0] >= CH_LO_A && w_data_r[7:0] <= CH_LO_Z) ?
                    w_data_r[7:0] - CH_CASE : w_data_r[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read side; early reads of unset widths are command errors.
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_bad = 1'b0;
        unique case (araddr)
            OFS_CTRL: rd_val = {28'h0000000, type_r, 2'b00};
            OFS_WAIT: rd_val = {16'h0000, wait_to_r};
            OFS_TRIG: begin
                rd_bad = !trig_set_r;
                rd_val = {15'h0000, pol_r, trig_w_r};
            end
            OFS_SAMP: begin
                rd_bad = !samp_set_r;
                rd_val = {16'h0000, samp_w_r};
            end
            OFS_STAT: rd_val = {err_code_r, 4'h0, idx_r, 1'b0, st_r,
                                trig_lvl_r, trig_role_r, 10'h000};
            OFS_LOOP: rd_val = {pass_r, loop_r};
            OFS_POINT: rd_val = {27'h0000000, n_lvl_r};
            OFS_DWELL: rd_val = {27'h0000000, n_dw_r};
            OFS_SPT: rd_val = {15'h0000, type_r == LTW_TY_CURR,
                               11'h000, samp_pt_r};
            OFS_SAVE: rd_val = {save_loop_r, 7'h00, save_segs_r,
                                save_slot_r};
            OFS_NAME: rd_val = {20'h00000, name_len_r,
                                ((name_len_r == 4'h0) ? 8'h00 :
                                 name_mem[name_len_r - 4'h1])};
            default: rd_bad = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_bad ? 32'h0000_0000 : rd_val;
            rresp_r <= rd_bad ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Last error; a new error wins over a status clear.
    assign rd_err = (arvalid && arready && rd_bad) ? ERR_CMD : ERR_NONE;
    always_ff @(posedge aclk) begin
        if (!aresetn) err_code_r <= ERR_NONE;
        else if (wr_go && wr_err != ERR_NONE) err_code_r <= wr_err;
        else if (rd_err != ERR_NONE) err_code_r <= rd_err;
        else if (wr_go && aw_addr_r == OFS_STAT) err_code_r <= ERR_NONE;
    end

    ////////////////////////////////////////////////////////////////////////
    // three-stage trigger synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            trig_lvl_r <= 1'b0;
        end else begin
            s1_r <= trig_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) trig_lvl_r <= s3_r;
        end
    end

    // Microsecond tick.
    assign tick = (pre_r == 6'(CYC_PER_US - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) pre_r <= 6'h00;
        else pre_r <= pre_r + 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || st_r == LTW_LOAD) elapsed_r <= 16'h0000;
        else if (tick && elapsed_r != 16'hffff) elapsed_r <= elapsed_r + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Point sequencer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= LTW_IDLE;
            idx_r <= '0;
            pass_r <= 16'h0000;
            level_out <= 16'h0000;
        end else begin
            unique case (st_r)
                LTW_IDLE: begin
                    if (wr_go && wr_err == ERR_NONE && aw_addr_r == OFS_CTRL
                        && w_data_r[CTRL_RUN] && !w_data_r[CTRL_CLR]
                        && n_lvl_r != '0) begin
                        idx_r <= '0;
                        pass_r <= 16'h0000;
                        st_r <= LTW_LOAD;
                    end
                end
                LTW_LOAD: begin
                    // skip first-pass points after pass one
                    if (pass_r != 16'h0000 && cur_pt[PT_INIT] && !last_pt)
                        idx_r <= idx_r + 1'b1;
                    else begin
                        level_out <= cur_pt[15:0];
                        unique case (ltw_kind_e'(cur_pt[PT_KIND_LO +: 2]))
                            LTW_PK_LEVEL: st_r <= LTW_LEVEL;
                            LTW_PK_PULSE: st_r <= LTW_PULSE;
                            LTW_PK_WAITHI: st_r <= LTW_WAITHI;
                            LTW_PK_WAITLO: st_r <= LTW_WAITLO;
                        endcase
                    end
                end
                default: begin
                    if ((st_r == LTW_LEVEL && elapsed_r >= dw_mem[idx_r]) ||
                        (st_r == LTW_PULSE && elapsed_r >= trig_w_r) ||
                        (st_r == LTW_WAITHI && (trig_lvl_r ||
                         (wait_to_r != 16'h0000 && elapsed_r >= wait_to_r)))
                        || (st_r == LTW_WAITLO && !trig_lvl_r)) begin
                        st_r <= LTW_LOAD;
                        if (!last_pt) idx_r <= idx_r + 1'b1;
                        else if (pass_r + 1'b1 < loop_r) begin
                            idx_r <= '0;
                            pass_r <= pass_r + 1'b1;
                        end else st_r <= LTW_IDLE;
                    end
                end
            endcase
        end
    end

    // switch state during and outside a pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) iso_switch_conduct <= 1'b0;
        else if (!trig_role_r) iso_switch_conduct <= out_off_flag;
        else iso_switch_conduct <= (st_r == LTW_PULSE) ? pol_r : !pol_r;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_hi_adv;
        (st_r == LTW_WAITHI && trig_lvl_r) |=> st_r != LTW_WAITHI;
    endproperty
    a_hi_adv: assert property (p_hi_adv)
        else $error("wait-high did not advance on trigger");
    property p_timeout;
        (st_r == LTW_WAITHI && wait_to_r != 16'h0000 &&
         elapsed_r >= wait_to_r) |=> st_r != LTW_WAITHI;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("wait-high ignored its time-out");
    property p_forever;
        (st_r == LTW_WAITHI && wait_to_r == 16'h0000 && !trig_lvl_r)
            |=> st_r == LTW_WAITHI;
    endproperty
    a_forever: assert property (p_forever)
        else $error("zero time-out did not wait");
    property p_range;
        wait_to_r == 16'h0000 || (wait_to_r >= T_MIN_US &&
                                  wait_to_r <= T_MAX_US);
    endproperty
    a_range: assert property (p_range)
        else $error("time-out outside legal window");
    property p_lo_hold;
        (st_r == LTW_WAITLO && trig_lvl_r) |=> st_r == LTW_WAITLO;
    endproperty
    a_lo_hold: assert property (p_lo_hold)
        else $error("wait-low advanced while trigger high");
    property p_restart;
        st_r == LTW_LOAD |=> elapsed_r == 16'h0000;
    endproperty
    a_restart: assert property (p_restart)
        else $error("elapsed time carried over");
    property p_pulse;
        (st_r == LTW_PULSE && trig_role_r) ##1 (st_r == LTW_PULSE)
            |-> iso_switch_conduct == pol_r;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("switch state wrong during pulse");
    property p_role;
        !trig_role_r ##1 !trig_role_r |-> iso_switch_conduct ==
            $past(out_off_flag);
    endproperty
    a_role: assert property (p_role)
        else $error("switch not showing output-off flag");
    property p_sync;
        $changed(trig_lvl_r) |-> $past(s2_r == s3_r);
    endproperty
    a_sync: assert property (p_sync)
        else $error("trigger level changed without agreement");

    c_timeout: cover property (st_r == LTW_WAITHI && !trig_lvl_r
        && wait_to_r != 16'h0000 ##1 st_r == LTW_LOAD);
    c_pulse: cover property (st_r == LTW_PULSE ##1 st_r == LTW_LOAD);
    c_lo: cover property (st_r == LTW_WAITLO ##1 st_r == LTW_LOAD);
endmodule : ltw_sequencer

// ### test/ltw_instr_model.sv
// Behavioural measuring instrument on the far side of the trigger pins.
// Assumes the sequencer's switch output and a stall control from the bench.
`timescale 1ns/10ps
module ltw_instr_model #(
    parameter int MEAS_CYC = 15000
) (
    input wire logic aclk, // Clock for timing the measurement.
    input wire logic iso_switch_conduct, // Trigger from the sequencer.
    input wire logic stall, // High: the measurement never completes.
    output logic trig_in // Wait line back to the sequencer.
);
    logic last_r = 1'b0;
    int cnt_r = 0;
    initial trig_in = 1'b1;
    always @(posedge aclk) begin
        last_r <= iso_switch_conduct;
        if (iso_switch_conduct && !last_r) begin
            trig_in <= 1'b0;
            cnt_r <= MEAS_CYC;
        end else if (cnt_r > 0) begin
            cnt_r <= cnt_r - 1;
            if (cnt_r == 1 && !stall)
                trig_in <= 1'b1;
        end
    end
endmodule : ltw_instr_model

// ### test/ltw_sequencer_tb.sv
// Self-checking bench for the list trigger/wait sequencer.
// Assumes a 50 MHz clock and the instrument model on the trigger pins.
`timescale 1ns/10ps
module ltw_sequencer_tb;
    import ltw_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, out_off_flag = 1, stall = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, iso, list_running;
    logic trig_in;
    logic [1:0] bresp, rresp;
    logic [15:0] level_out;
    int errors = 0, comparisons = 0, n;
    always #10 aclk = ~aclk;
    ltw_sequencer ltw_sequencer_i (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .trig_in(trig_in),
        .out_off_flag(out_off_flag), .iso_switch_conduct(iso),
        .level_out(level_out), .list_running(list_running));
    ltw_instr_model ltw_instr_model_i (.aclk(aclk),
        .iso_switch_conduct(iso), .stall(stall), .trig_in(trig_in));
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task end_sim;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        logic ad, dd, g;
        logic [1:0] r;
        ad = 0;
        dd = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        while (!(ad && dd)) begin
            @(negedge aclk);
            ad = ad | (awvalid & awready);
            dd = dd | (wvalid & wready);
            @(posedge aclk);
            if (ad) awvalid <= 0;
            if (dd) wvalid <= 0;
        end
        bready <= 1;
        do begin
            @(negedge aclk);
            g = bvalid;
            r = bresp;
            @(posedge aclk);
        end while (g !== 1'b1);
        bready <= 0;
        chk("bresp", r, e);
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] e);
        logic ad, g;
        logic [1:0] r;
        ad = 0;
        araddr <= a;
        arvalid <= 1;
        while (!ad) begin
            @(negedge aclk);
            ad = arready;
            @(posedge aclk);
        end
        arvalid <= 0;
        rready <= 1;
        do begin
            @(negedge aclk);
            g = rvalid;
            r = rresp;
            v = rdata;
            @(posedge aclk);
        end while (g !== 1'b1);
        rready <= 0;
        chk("rresp", r, e);
    endtask : rd
    task wait_lvl(input logic [15:0] v);
        n = 0;
        while (level_out !== v && n < 40000) begin
            @(posedge aclk);
            n++;
        end
    endtask : wait_lvl
    int n1 = 0;
    logic [15:0] lvl_q = 16'h0000;
    always @(posedge aclk) begin
        lvl_q <= level_out;
        if (level_out == 16'h1111 && lvl_q != 16'h1111) n1 <= n1 + 1;
    end
    task t_reset;
        rd(OFS_WAIT, d, RESP_OKAY);
        chk("wait", d, 0);
        rd(OFS_TRIG, d, RESP_SLVERR);
        rd(OFS_SAMP, d, RESP_SLVERR);
        rd(8'h3c, d, RESP_SLVERR);
        out_off_flag <= 0;
        repeat (4) @(posedge aclk);
        chk("flag", iso, 0);
    endtask : t_reset
    task t_ranges;
        wr(OFS_WAIT, T_MIN_US - 1, RESP_SLVERR);
        wr(OFS_WAIT, T_MAX_US, RESP_OKAY);
        rd(OFS_WAIT, d, RESP_OKAY);
        chk("wait", d, T_MAX_US);
        wr(OFS_SAMP, T_MIN_US, RESP_OKAY);
        wr(OFS_SAMP, T_MIN_US, RESP_SLVERR);
    endtask : t_ranges
    task t_conflict;
        wr(OFS_POINT, 32'h0001_1234, RESP_SLVERR);
        wr(OFS_CTRL, 32'h4, RESP_OKAY);
        wr(OFS_POINT, 32'h0001_1234, RESP_SLVERR);
        rd(OFS_STAT, d, RESP_OKAY);
        chk("err", d[31:24], ERR_CONFLICT);
        wr(OFS_WAIT, T_MIN_US, RESP_OKAY);
        wr(OFS_TRIG, 32'h0001_0000 | T_MIN_US, RESP_OKAY);
        wr(OFS_POINT, 32'h0001_1234, RESP_OKAY);
        wr(OFS_POINT, 32'h0002_5678, RESP_OKAY);
        wr(OFS_POINT, 32'h0000_9abc, RESP_OKAY);
        wr(OFS_CTRL, 32'h5, RESP_SLVERR);
        repeat (3) wr(OFS_DWELL, 32'h1, RESP_OKAY);
    endtask : t_conflict
    task wait_idle;
        while (list_running !== 1'b0) @(posedge aclk);
        chk("running", list_running, 0);
    endtask : wait_idle
    task t_run(input logic s);
        stall <= s;
        wr(OFS_CTRL, 32'h5, RESP_OKAY);
        wait_lvl(16'h1234);
        repeat (5) @(posedge aclk);
        chk("on", iso, 1);
        wait_lvl(16'h5678);
        chk("pulse", n >= 12440 && n <= 12520, 1);
        chk("idle", iso, 0);
        wait_lvl(16'h9abc);
        if (s)
            chk("tmo", n >= 12440 && n <= 12520, 1);
        else
            chk("trig", n >= 2400 && n <= 2650, 1);
        wait_idle;
    endtask : t_run
    task t_clear;
        stall <= 0;
        out_off_flag <= 1;
        repeat (3) @(posedge aclk);
        chk("role", iso, 0);
        wr(OFS_CTRL, 32'h2, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("role", iso, 1);
    endtask : t_clear
    task t_loop;
        wr(OFS_CTRL, 32'h8, RESP_OKAY);
        wr(OFS_LOOP, 32'h2, RESP_OKAY);
        wr(OFS_SPT, 32'h3, RESP_OKAY);
        rd(OFS_SPT, d, RESP_OKAY);
        chk("spt", d, 32'h0001_0003);
        wr(OFS_POINT, 32'h0007_1111, RESP_OKAY);
        wr(OFS_POINT, 32'h0000_2222, RESP_OKAY);
        wr(OFS_POINT, 32'h0000_3333, RESP_OKAY);
        repeat (3) wr(OFS_DWELL, 32'h1, RESP_OKAY);
        wr(OFS_SAVE, 32'h10, RESP_SLVERR);
        wr(OFS_NAME, 32'h61, RESP_OKAY);
        rd(OFS_NAME, d, RESP_OKAY);
        chk("name", d, 32'h141);
        wr(OFS_NAME, 32'h162, RESP_OKAY);
        rd(OFS_NAME, d, RESP_OKAY);
        chk("name", d, 32'h262);
        wr(OFS_SAVE, 32'h10, RESP_OKAY);
        rd(OFS_SAVE, d, RESP_OKAY);
        chk("save", d, 32'h0002_0070);
        while (trig_in !== 1'b1) @(posedge aclk);
        wr(OFS_CTRL, 32'h9, RESP_OKAY);
        wait_lvl(16'h1111);
        repeat (20) @(posedge aclk);
        chk("hold", level_out, 16'h1111);
        out_off_flag <= 0;
        @(posedge aclk);
        out_off_flag <= 1;
        wait_idle;
        rd(OFS_LOOP, d, RESP_OKAY);
        chk("pass", d, 32'h0001_0002);
        chk("first", n1, 1);
    endtask : t_loop
    initial begin
        #1_800_000;
        errors++;
        end_sim;
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset;
        t_ranges;
        t_conflict;
        t_run(0);
        t_run(1);
        t_clear;
        t_loop;
        end_sim;
    end
endmodule : ltw_sequencer_tb
